// [hdl/csbu_defines.vh]
`ifndef CSBU_DEFINES_VH
`define CSBU_DEFINES_VH

// Operation codes from the instruction decoder
`define CSBU_OP_SKIP_REG_BIT_CLEAR 3'h0
`define CSBU_OP_SKIP_REG_BIT_SET 3'h1
`define CSBU_OP_SKIP_IO_BIT_CLEAR 3'h2
`define CSBU_OP_SKIP_IO_BIT_SET 3'h3
`define CSBU_OP_BRANCH_FLAG_SET 3'h4
`define CSBU_OP_BRANCH_FLAG_CLEAR 3'h5
`define CSBU_OP_BRANCH_EQUAL 3'h6
`define CSBU_OP_BRANCH_NOT_EQUAL 3'h7

// Extra cycles beyond the first
`define CSBU_EXTRA_NONE 2'h0
`define CSBU_EXTRA_ONE 2'h1
`define CSBU_EXTRA_TWO 2'h2

// Program counter steps in words
`define CSBU_STEP_NEXT 2'h1
`define CSBU_STEP_SKIP_ONE 2'h2
`define CSBU_STEP_SKIP_TWO 2'h3

// Reset values
`define CSBU_RESET_STATE 1'h0
`define CSBU_RESET_CNT 2'h0
`define CSBU_RESET_DONE 1'h0
`define CSBU_RESET_TAKEN 1'h0
`define CSBU_RESET_TARGET 1'h0

`endif

// [hdl/csbu_unit.v]
`timescale 1ns/100ps
`include "csbu_defines.vh"

module csbu_unit #(
    parameter PC_W = 16,
    parameter K_W = 7,
    parameter ZERO_BIT = 1
) (
    input wire clk_sys,
    input wire reset_n,
    input wire instr_valid,
    input wire [2:0] instr_op,
    input wire [2:0] bit_sel,
    input wire [7:0] reg_value,
    input wire [7:0] io_value,
    input wire [7:0] status_value,
    input wire [K_W-1:0] offset_k,
    input wire [PC_W-1:0] pc_value,
    input wire next_two_word,
    output wire busy_q,
    output reg done_q,
    output reg taken_q,
    output reg [PC_W-1:0] pc_target_q
);

    localparam ST_IDLE = 1'h0;
    localparam ST_WAIT = 1'h1;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function [PC_W-1:0] pc_add;
        input [PC_W-1:0] base;
        input [PC_W-1:0] step;
        begin
            pc_add = base + step;
        end
    endfunction

    function [PC_W-1:0] sext_k;
        input [K_W-1:0] k;
        begin
            sext_k = {{(PC_W-K_W){k[K_W-1]}}, k};
        end
    endfunction

    function [PC_W-1:0] step_word;
        input [1:0] step;
        begin
            step_word = {{(PC_W-2){1'h0}}, step};
        end
    endfunction

    function pick_bit;
        input [7:0] value;
        input [2:0] index;
        begin
            pick_bit = value[index];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Condition and target

    reg state_q;
    reg [1:0] cnt_q;
    reg take_d;
    reg is_branch_d;
    reg [1:0] extra_d;
    reg [PC_W-1:0] target_d;
    wire reg_bit = pick_bit(reg_value, bit_sel);
    wire io_bit = pick_bit(io_value, bit_sel);
    wire flag_bit = pick_bit(status_value, bit_sel);
    wire zero_bit = status_value[ZERO_BIT];
    wire accept = instr_valid & (state_q == ST_IDLE);
    wire last_extra = (state_q == ST_WAIT) && (cnt_q == `CSBU_EXTRA_ONE);
    wire finish_now = (accept && (extra_d == `CSBU_EXTRA_NONE)) || last_extra;
    wire [PC_W-1:0] pc_next = pc_add(pc_value, step_word(`CSBU_STEP_NEXT));
    wire [PC_W-1:0] pc_skip_one = pc_add(pc_value, step_word(`CSBU_STEP_SKIP_ONE));
    wire [PC_W-1:0] pc_skip_two = pc_add(pc_value, step_word(`CSBU_STEP_SKIP_TWO));
    wire [PC_W-1:0] pc_branch = pc_add(pc_add(pc_value, sext_k(offset_k)),
        step_word(`CSBU_STEP_NEXT));

    assign busy_q = state_q;

    // Skip and branch conditions
    always @* begin
        take_d = 1'h0;
        case (instr_op)
            `CSBU_OP_SKIP_REG_BIT_CLEAR: begin
                take_d = ~reg_bit;
            end
            `CSBU_OP_SKIP_REG_BIT_SET: begin
                take_d = reg_bit;
            end
            `CSBU_OP_SKIP_IO_BIT_CLEAR: begin
                take_d = ~io_bit;
            end
            `CSBU_OP_SKIP_IO_BIT_SET: begin
                take_d = io_bit;
            end
            `CSBU_OP_BRANCH_FLAG_SET: begin
                take_d = flag_bit;
            end
            `CSBU_OP_BRANCH_FLAG_CLEAR: begin
                take_d = ~flag_bit;
            end
            `CSBU_OP_BRANCH_EQUAL: begin
                take_d = zero_bit;
            end
            `CSBU_OP_BRANCH_NOT_EQUAL: begin
                take_d = ~zero_bit;
            end
            default: begin
                take_d = 1'h0;
            end
        endcase
    end

    // Operation class
    always @* begin
        is_branch_d = 1'h0;
        case (instr_op)
            `CSBU_OP_BRANCH_FLAG_SET,
            `CSBU_OP_BRANCH_FLAG_CLEAR,
            `CSBU_OP_BRANCH_EQUAL,
            `CSBU_OP_BRANCH_NOT_EQUAL: begin
                is_branch_d = 1'h1;
            end
            default: begin
                is_branch_d = 1'h0;
            end
        endcase
    end

    // Next program counter
    always @* begin
        extra_d = `CSBU_EXTRA_NONE;
        target_d = pc_next;
        if (take_d && is_branch_d) begin
            extra_d = `CSBU_EXTRA_ONE;
            target_d = pc_branch;
        end else if (take_d && next_two_word) begin
            extra_d = `CSBU_EXTRA_TWO;
            target_d = pc_skip_two;
        end else if (take_d) begin
            extra_d = `CSBU_EXTRA_ONE;
            target_d = pc_skip_one;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencing; status flags are never written

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= `CSBU_RESET_STATE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept && (extra_d != `CSBU_EXTRA_NONE)) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (last_extra) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= `CSBU_RESET_CNT;
        end else if (accept) begin
            cnt_q <= extra_d;
        end else if (state_q == ST_WAIT) begin
            cnt_q <= cnt_q - `CSBU_EXTRA_ONE;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= `CSBU_RESET_DONE;
        end else if (finish_now) begin
            done_q <= 1'h1;
        end else begin
            done_q <= 1'h0;
        end
    end

    // taken_q and pc_target_q hold until the next accept
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            taken_q <= `CSBU_RESET_TAKEN;
        end else if (accept) begin
            taken_q <= take_d;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pc_target_q <= {PC_W{`CSBU_RESET_TARGET}};
        end else if (accept) begin
            pc_target_q <= target_d;
        end
    end

endmodule

// [verification/csbu_unit_bench.sv]
`timescale 1ns/100ps
module csbu_unit_bench;
    logic clk_sys = 1'h0, reset_n = 1'h0, instr_valid = 1'h0, next_two_word = 1'h0;
    logic [2:0] instr_op = 3'h0, bit_sel = 3'h0;
    logic [7:0] reg_value = 8'h00, io_value = 8'h00, status_value = 8'h00;
    logic [6:0] offset_k = 7'h00;
    logic [15:0] pc_value = 16'h0020;
    wire busy_q, done_q, taken_q;
    wire [15:0] pc_target_q;
    int fail_count = 0, comparisons = 0, ticks = 0;
    csbu_unit dut (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .instr_valid(instr_valid),
        .instr_op(instr_op),
        .bit_sel(bit_sel),
        .reg_value(reg_value),
        .io_value(io_value),
        .status_value(status_value),
        .offset_k(offset_k),
        .pc_value(pc_value),
        .next_two_word(next_two_word),
        .busy_q(busy_q),
        .done_q(done_q),
        .taken_q(taken_q),
        .pc_target_q(pc_target_q)
    );
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        ticks++;
        if (ticks == 3000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    task chk(input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %h %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (fail_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic run(input logic [2:0] op, logic [7:0] v, logic [2:0] b, logic [6:0] k,
            logic two);
        int n = 1;
        logic hit = v[op > 5 ? 1 : b] ^ (op inside {0, 2, 5, 7});
        logic [15:0] dest;
        dest = !hit ? pc_value + 16'h1 : op < 4 ? pc_value + (two ? 16'h3 : 16'h2)
            : pc_value + {{9{k[6]}}, k} + 16'h1;
        {instr_op, bit_sel, offset_k, next_two_word, instr_valid} = {op, b, k, two, 1'h1};
        {reg_value, io_value, status_value} = op < 2 ? {v, ~v, ~v}
            : op < 4 ? {~v, v, ~v} : {~v, ~v, v};
        @(negedge clk_sys);
        while (done_q !== 1'h1 && n < 8) begin
            n++;
            @(negedge clk_sys);
        end
        chk(taken_q, hit);
        chk(pc_target_q, dest);
        chk(busy_q, 1'h0);
        chk(n, hit ? (op < 4 && two ? 3 : 2) : 1);
    endtask
    task t_skip;
        for (int i = 0; i < 16; i++) run({1'h0, i[1:0]}, i[2] ? 8'h80 : 8'h7F, 3'h7, 7'h00, i[3]);
    endtask
    task t_branch;
        for (int i = 0; i < 16; i++) run(3'h4 + i[1:0], i[2] ? 8'h40 : 8'h02, 3'h6,
            i[3] ? 7'h40 : 7'h3F, 1'h1);
    endtask
    task t_reset;
        {instr_op, bit_sel, next_two_word, instr_valid} = {3'h0, 3'h0, 1'h1, 1'h1};
        reg_value = 8'h00;
        @(negedge clk_sys);
        reset_n = 1'h0;
        instr_valid = 1'h0;
        @(negedge clk_sys);
        chk({busy_q, done_q, taken_q}, 3'h0);
        chk(pc_target_q, 16'h0000);
        reset_n = 1'h1;
        run(3'h3, 8'h01, 3'h0, 7'h01, 1'h0);
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        reset_n = 1'h1;
        t_skip;
        t_branch;
        t_reset;
        tally_and_finish;
    end
endmodule

// [verification/csbu_unit_properties.sv]
`timescale 1ns/100ps
module csbu_props (
    input wire clk_sys,
    input wire reset_n,
    input wire instr_valid,
    input wire next_two_word,
    input wire busy_q,
    input wire done_q,
    input wire taken_q,
    input wire [2:0] instr_op,
    input wire [2:0] bit_sel,
    input wire [7:0] reg_value,
    input wire [7:0] io_value,
    input wire [7:0] status_value,
    input wire [6:0] offset_k,
    input wire [15:0] pc_value,
    input wire [15:0] pc_target_q
);
    wire acc = instr_valid && !busy_q;
    wire [2:0] op = instr_op;
    wire lng = op < 4 && next_two_word;
    wire [7:0] src = op < 2 ? reg_value : op < 4 ? io_value : status_value;
    wire hit = src[op > 5 ? 1 : bit_sel] ^ (op inside {0, 2, 5, 7});
    wire [15:0] tgt = !hit ? pc_value + 16'h1 : op < 4 ? pc_value + 16'h2 + lng
        : pc_value + {{9{offset_k[6]}}, offset_k} + 16'h1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_hit; acc |=> taken_q == $past(hit); endproperty
    property p_tg; acc |=> pc_target_q == $past(tgt); endproperty
    property p_one; acc && !hit |=> done_q; endproperty
    property p_two; acc && hit && !lng |=> busy_q ##1 done_q && !busy_q; endproperty
    property p_three; acc && hit && lng |=> busy_q [*2] ##1 done_q && !busy_q; endproperty
    property p_hold; !acc |=> $stable(pc_target_q) && $stable(taken_q); endproperty
    property p_excl; busy_q |-> !done_q; endproperty
    property p_idle; !acc && !busy_q |=> !done_q; endproperty
    a_hit: assert property (p_hit) else $error("taken");
    a_tg: assert property (p_tg) else $error("target");
    a_one: assert property (p_one) else $error("one");
    a_two: assert property (p_two) else $error("two");
    a_three: assert property (p_three) else $error("three");
    a_hold: assert property (p_hold) else $error("hold");
    a_excl: assert property (p_excl) else $error("excl");
    a_idle: assert property (p_idle) else $error("idle");
    cover property (acc && hit && lng);
    cover property (acc && hit && offset_k[6]);
    cover property (instr_valid && busy_q);
endmodule
bind csbu_unit csbu_props u_props (.*);
